// >>> include/vmc_pkg.sv
// Package with the layout, reset values and timing of the voltage monitor configuration bank.
package vmc_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets on the serial configuration port
  // ---------------------------------------------------------------------------
  localparam logic [7:0] VMC_OFS_CONTROL     = 8'h2B;
  localparam logic [7:0] VMC_OFS_ANA_WINDOW  = 8'h2C;
  localparam logic [7:0] VMC_OFS_ONE_WINDOW  = 8'h2D;
  localparam logic [7:0] VMC_OFS_ONE_LEVEL   = 8'h2E;
  localparam logic [7:0] VMC_OFS_TWO_WINDOW  = 8'h2F;
  localparam logic [7:0] VMC_OFS_TWO_LEVEL   = 8'h30;

  // ---------------------------------------------------------------------------
  // Values after reset and read value of an unmapped address
  // ---------------------------------------------------------------------------
  localparam logic [7:0] VMC_RST_REG         = 8'h00;
  localparam logic [7:0] VMC_UNMAPPED_RDATA  = 8'h00;

  // ---------------------------------------------------------------------------
  // Filter timing at the 250 MHz core clock
  // ---------------------------------------------------------------------------
  localparam int         VMC_CLK_MHZ         = 250;
  localparam int         VMC_FILTER_SHORT_US = 4;
  localparam int         VMC_FILTER_LONG_US  = 20;
  localparam int         VMC_FILTER_SHORT_CYC = VMC_FILTER_SHORT_US * VMC_CLK_MHZ;
  localparam int         VMC_FILTER_LONG_CYC  = VMC_FILTER_LONG_US * VMC_CLK_MHZ;
  localparam int         VMC_FILTER_CNT_W    = 13;
  localparam logic [2:0] VMC_FILTER_CODE_SHORT = 3'h0;

  // Extended range scales the millivolt offsets by five.
  localparam int         VMC_EXT_RANGE_SCALE = 5;

  // ---------------------------------------------------------------------------
  // Register layouts
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] monitor_filter_time_select;      // Bits 7:5.
    logic       monitor_two_residual_check;      // Bit 4.
    logic       monitor_two_comparator_enable;   // Bit 3.
    logic       monitor_one_residual_check;      // Bit 2.
    logic       monitor_one_comparator_enable;   // Bit 1.
    logic       analog_supply_comparator_enable; // Bit 0.
  } vmc_ctrl_t;

  typedef struct packed {
    logic       spare;        // Bit 7, stored only.
    logic       range_select; // Bit 6, nominal select for the analog supply.
    logic [2:0] low_code;     // Bits 5:3.
    logic [2:0] high_code;    // Bits 2:0.
  } vmc_win_t;

  // Whole configuration image, also the shape of the nonvolatile default.
  typedef struct packed {
    vmc_ctrl_t  ctrl;
    vmc_win_t   ana_win;
    vmc_win_t   one_win;
    logic [7:0] one_level;
    vmc_win_t   two_win;
    logic [7:0] two_level;
  } vmc_cfg_t;

  // Decoded window for one monitor: tenths of a percent and millivolts.
  typedef struct packed {
    logic [6:0] low_pct_x10;
    logic [6:0] high_pct_x10;
    logic [9:0] low_mv;
    logic [9:0] high_mv;
  } vmc_thr_t;

endpackage

// >>> src/vmc_bank.sv
// Voltage monitor configuration bank with window decode and comparator filtering.
`timescale 1ns/1ns

module vmc_bank #(
  parameter int P_FILTER_LONG_CYC = vmc_pkg::VMC_FILTER_LONG_CYC
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_nvm_valid,
  input  wire vmc_pkg::vmc_cfg_t i_nvm_image,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  output logic [7:0]             o_reg_rdata,
  output logic                   o_reg_rvalid,
  input  wire logic [2:0]        i_cmp_high,
  input  wire logic [2:0]        i_cmp_low,
  output logic [2:0]             o_high_flag,
  output logic [2:0]             o_low_flag,
  output logic                   o_cfg_ready,
  output vmc_pkg::vmc_cfg_t      o_cfg,
  output logic [1:0]             o_residual_check,
  output vmc_pkg::vmc_thr_t      o_ana_thr,
  output vmc_pkg::vmc_thr_t      o_one_thr,
  output vmc_pkg::vmc_thr_t      o_two_thr
);
  import vmc_pkg::*;

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  vmc_cfg_t                    cfg_r;
  logic                        ready_r;
  logic [2:0]                  mon_en;
  logic [5:0]                  raw;
  logic [5:0]                  flag_r;
  logic [VMC_FILTER_CNT_W-1:0] cnt_r [6];
  logic [VMC_FILTER_CNT_W-1:0] limit;

  // Decode of a three-bit window code into tenths of a percent.
  function automatic logic [6:0] code_pct(input logic [2:0] code);
    logic [6:0] pct;
    pct = 7'd30;
    unique case (code)
      3'd0: pct = 7'd30;
      3'd1: pct = 7'd35;
      3'd2: pct = 7'd40;
      3'd3: pct = 7'd50;
      3'd4: pct = 7'd60;
      3'd5: pct = 7'd70;
      3'd6: pct = 7'd80;
      3'd7: pct = 7'd100;
    endcase
    return pct;
  endfunction

  // Millivolt offset; normal range equals the tenth-percent figure numerically.
  function automatic logic [9:0] code_mv(input logic [2:0] code, input logic ext);
    logic [9:0] mv;
    mv = {3'h0, code_pct(code)};
    if (ext)
    begin
      mv = 10'(mv * VMC_EXT_RANGE_SCALE);
    end
    return mv;
  endfunction

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  // Nonvolatile load wins over a host write in the same cycle, so the image is
  // always complete. Host writes before the load are dropped because the load
  // would overwrite them anyway.
  // default load
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg_r <= {6{VMC_RST_REG}};
    end
    else if (i_nvm_valid)
    begin
      cfg_r <= i_nvm_image;
    end
    else if (i_reg_wr && ready_r)
    begin
      unique case (i_reg_addr)
        VMC_OFS_CONTROL:    cfg_r.ctrl      <= i_reg_wdata;
        VMC_OFS_ANA_WINDOW: cfg_r.ana_win   <= i_reg_wdata;
        VMC_OFS_ONE_WINDOW: cfg_r.one_win   <= i_reg_wdata;
        VMC_OFS_ONE_LEVEL:  cfg_r.one_level <= i_reg_wdata;
        VMC_OFS_TWO_WINDOW: cfg_r.two_win   <= i_reg_wdata;
        VMC_OFS_TWO_LEVEL:  cfg_r.two_level <= i_reg_wdata;
        default:            cfg_r           <= cfg_r;
      endcase
    end
  end

  // The bank is usable once the first default image has arrived.
  // ready after load
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ready_r <= 1'b0;
    end
    else if (i_nvm_valid)
    begin
      ready_r <= 1'b1;
    end
  end

  // Read port answers one cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_reg_rdata  <= VMC_UNMAPPED_RDATA;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd)
      begin
        unique case (i_reg_addr)
          VMC_OFS_CONTROL:    o_reg_rdata <= cfg_r.ctrl;
          VMC_OFS_ANA_WINDOW: o_reg_rdata <= cfg_r.ana_win;
          VMC_OFS_ONE_WINDOW: o_reg_rdata <= cfg_r.one_win;
          VMC_OFS_ONE_LEVEL:  o_reg_rdata <= cfg_r.one_level;
          VMC_OFS_TWO_WINDOW: o_reg_rdata <= cfg_r.two_win;
          VMC_OFS_TWO_LEVEL:  o_reg_rdata <= cfg_r.two_level;
          default:            o_reg_rdata <= VMC_UNMAPPED_RDATA;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration outputs
  // ---------------------------------------------------------------------------
  // Levels and range bits go out as stored.
  // level one out
  assign o_cfg       = cfg_r;
  assign o_cfg_ready = ready_r;

  // Residual checking follows the control bits.
  // residual two
  assign o_residual_check = {cfg_r.ctrl.monitor_two_residual_check,
                             cfg_r.ctrl.monitor_one_residual_check};

  // Analog supply window: percent only, the nominal bit picks 3.3 V or 5.0 V.
  // nominal select
  assign o_ana_thr = '{low_pct_x10:  code_pct(cfg_r.ana_win.low_code),
                       high_pct_x10: code_pct(cfg_r.ana_win.high_code),
                       low_mv:       10'h000,
                       high_mv:      10'h000};

  // General monitors; the spare bit 7 is deliberately not used anywhere.
  // range select
  assign o_one_thr = '{low_pct_x10:  code_pct(cfg_r.one_win.low_code),
                       high_pct_x10: code_pct(cfg_r.one_win.high_code),
                       low_mv:       code_mv(cfg_r.one_win.low_code, cfg_r.one_win.range_select),
                       high_mv:      code_mv(cfg_r.one_win.high_code, cfg_r.one_win.range_select)};
  assign o_two_thr = '{low_pct_x10:  code_pct(cfg_r.two_win.low_code),
                       high_pct_x10: code_pct(cfg_r.two_win.high_code),
                       low_mv:       code_mv(cfg_r.two_win.low_code, cfg_r.two_win.range_select),
                       high_mv:      code_mv(cfg_r.two_win.high_code, cfg_r.two_win.range_select)};

  // ---------------------------------------------------------------------------
  // Comparator filtering
  // ---------------------------------------------------------------------------
  // Only codes zero and one are defined; higher codes take the long time as the
  // safer choice against nuisance trips.
  // filter time
  assign limit = (cfg_r.ctrl.monitor_filter_time_select == VMC_FILTER_CODE_SHORT)
               ? VMC_FILTER_CNT_W'(VMC_FILTER_SHORT_CYC)
               : VMC_FILTER_CNT_W'(P_FILTER_LONG_CYC);

  // Comparator enables gated by a loaded configuration.
  // monitor two enable
  assign mon_en = {3{ready_r}} & {cfg_r.ctrl.monitor_two_comparator_enable,
                                  cfg_r.ctrl.monitor_one_comparator_enable,
                                  cfg_r.ctrl.analog_supply_comparator_enable};
  assign raw    = {i_cmp_low, i_cmp_high};

  // Each flag follows its comparator only after the level has differed for the
  // full filter time; any bounce restarts the count.
  for (genvar ch = 0; ch < 6; ch++)
  begin : g_filter
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        cnt_r[ch]  <= '0;
        flag_r[ch] <= 1'b0;
      end
      else if (!mon_en[ch % 3])
      begin
        cnt_r[ch]  <= '0;
        flag_r[ch] <= 1'b0;
      end
      else if (raw[ch] == flag_r[ch])
      begin
        cnt_r[ch] <= '0;
      end
      else if (cnt_r[ch] >= limit - VMC_FILTER_CNT_W'(1))
      begin
        cnt_r[ch]  <= '0;
        flag_r[ch] <= raw[ch];
      end
      else
      begin
        cnt_r[ch] <= cnt_r[ch] + VMC_FILTER_CNT_W'(1);
      end
    end
  end

  assign o_high_flag = flag_r[2:0];
  assign o_low_flag  = flag_r[5:3];

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_win_wr(logic [7:0] ofs);
    i_reg_wr && ready_r && !i_nvm_valid && i_reg_addr == ofs;
  endsequence
  property p_filter_time;
    $rose(flag_r[0]) |-> $past(cnt_r[0]) == $past(limit) - VMC_FILTER_CNT_W'(1);
  endproperty
  a_filter_time: assert property (p_filter_time) else $error("flag set before filter time");
  property p_short_code;
    cfg_r.ctrl.monitor_filter_time_select == VMC_FILTER_CODE_SHORT |-> limit == VMC_FILTER_CNT_W'(1000);
  endproperty
  a_short_code: assert property (p_short_code) else $error("short filter count wrong");
  property p_residual_two;
    s_win_wr(VMC_OFS_CONTROL) ##1 1'b1 |-> o_residual_check[1] == $past(i_reg_wdata[4]);
  endproperty
  a_residual_two: assert property (p_residual_two) else $error("residual two not updated");
  property p_en_two;
    s_win_wr(VMC_OFS_CONTROL) ##1 1'b1 |-> mon_en[2] == $past(i_reg_wdata[3]);
  endproperty
  a_en_two: assert property (p_en_two) else $error("monitor two enable not updated");
  property p_residual_one;
    s_win_wr(VMC_OFS_CONTROL) ##1 1'b1 |-> o_residual_check[0] == $past(i_reg_wdata[2]);
  endproperty
  a_residual_one: assert property (p_residual_one) else $error("residual one not updated");
  property p_en_one;
    s_win_wr(VMC_OFS_CONTROL) ##1 1'b1 |-> mon_en[1] == $past(i_reg_wdata[1]);
  endproperty
  a_en_one: assert property (p_en_one) else $error("monitor one enable not updated");
  property p_en_ana;
    s_win_wr(VMC_OFS_CONTROL) ##1 1'b1 |-> mon_en[0] == $past(i_reg_wdata[0]);
  endproperty
  a_en_ana: assert property (p_en_ana) else $error("analog enable not updated");
  property p_ana_nominal;
    s_win_wr(VMC_OFS_ANA_WINDOW) ##1 1'b1 |-> o_cfg.ana_win.range_select == $past(i_reg_wdata[6]);
  endproperty
  a_ana_nominal: assert property (p_ana_nominal) else $error("nominal select not updated");
  property p_ana_low_top;
    o_cfg.ana_win.low_code == 3'd7 |-> o_ana_thr.low_pct_x10 == 7'd100;
  endproperty
  a_ana_low_top: assert property (p_ana_low_top) else $error("analog low top code wrong");
  property p_ana_high_second;
    o_cfg.ana_win.high_code == 3'd1 |-> o_ana_thr.high_pct_x10 == 7'd35;
  endproperty
  a_ana_high_second: assert property (p_ana_high_second) else $error("analog high code wrong");
  property p_ext_range;
    o_cfg.one_win.range_select && o_cfg.one_win.low_code == 3'd0 |-> o_one_thr.low_mv == 10'd150;
  endproperty
  a_ext_range: assert property (p_ext_range) else $error("extended range not applied");
  property p_one_low;
    o_cfg.one_win.low_code == 3'd5 |-> o_one_thr.low_pct_x10 == 7'd70;
  endproperty
  a_one_low: assert property (p_one_low) else $error("monitor one low wrong");
  property p_one_high;
    !o_cfg.one_win.range_select |-> o_one_thr.high_mv == {3'h0, o_one_thr.high_pct_x10};
  endproperty
  a_one_high: assert property (p_one_high) else $error("monitor one high wrong");
  property p_two_low;
    o_cfg.two_win.range_select && o_cfg.two_win.low_code == 3'd1 |-> o_two_thr.low_mv == 10'd175;
  endproperty
  a_two_low: assert property (p_two_low) else $error("monitor two low wrong");
  property p_two_high;
    o_cfg.two_win.range_select && o_cfg.two_win.high_code == 3'd7 |-> o_two_thr.high_mv == 10'd500;
  endproperty
  a_two_high: assert property (p_two_high) else $error("monitor two high wrong");
  property p_level_one;
    s_win_wr(VMC_OFS_ONE_LEVEL) ##1 (!i_reg_wr && !i_nvm_valid) ##1 (i_reg_rd && i_reg_addr == VMC_OFS_ONE_LEVEL)
      |=> o_reg_rvalid && o_reg_rdata == $past(i_reg_wdata, 3);
  endproperty
  a_level_one: assert property (p_level_one) else $error("level one readback wrong");
  property p_level_two;
    s_win_wr(VMC_OFS_TWO_LEVEL) ##1 1'b1 |-> o_cfg.two_level == $past(i_reg_wdata);
  endproperty
  a_level_two: assert property (p_level_two) else $error("level two not updated");
  property p_no_flag_before_load;
    !ready_r |-> o_high_flag == 3'h0 && o_low_flag == 3'h0;
  endproperty
  a_no_flag_before_load: assert property (p_no_flag_before_load) else $error("flag before load");
  property p_disabled_quiet;
    !mon_en[1] |=> !o_high_flag[1] && !o_low_flag[1];
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled monitor flagged");

endmodule // vmc_bank

// >>> test/vmc_bank_tb.sv
// Self-checking bench for the voltage monitor configuration bank.
`timescale 1ns/1ns

module vmc_bank_tb;
  import vmc_pkg::*;

  // ---------------------------------------------------------------------------
  // Signals and design instance
  // ---------------------------------------------------------------------------
  // Short long-filter count keeps the run brief; expectations use it too.
  localparam int LONG_CYC = 20;
  localparam int SHORT_CYC = 1000;
  logic       clk;
  logic       rst_n;
  logic       nvm_valid;
  vmc_cfg_t   nvm_image;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic [2:0] cmp_high;
  logic [2:0] cmp_low;
  logic [2:0] high_flag;
  logic [2:0] low_flag;
  logic       cfg_ready;
  vmc_cfg_t   cfg;
  logic [1:0] residual;
  vmc_thr_t   ana_thr;
  vmc_thr_t   one_thr;
  vmc_thr_t   two_thr;
  int         errors;
  int         check_count;
  logic [7:0] ofs [6] = '{VMC_OFS_CONTROL, VMC_OFS_ANA_WINDOW, VMC_OFS_ONE_WINDOW,
                          VMC_OFS_ONE_LEVEL, VMC_OFS_TWO_WINDOW, VMC_OFS_TWO_LEVEL};

  vmc_bank #(.P_FILTER_LONG_CYC(LONG_CYC)) vmc_bank_i (
    .i_core_clk       (clk),
    .i_rst_n          (rst_n),
    .i_nvm_valid      (nvm_valid),
    .i_nvm_image      (nvm_image),
    .i_reg_wr         (reg_wr),
    .i_reg_rd         (reg_rd),
    .i_reg_addr       (reg_addr),
    .i_reg_wdata      (reg_wdata),
    .o_reg_rdata      (reg_rdata),
    .o_reg_rvalid     (reg_rvalid),
    .i_cmp_high       (cmp_high),
    .i_cmp_low        (cmp_low),
    .o_high_flag      (high_flag),
    .o_low_flag       (low_flag),
    .o_cfg_ready      (cfg_ready),
    .o_cfg            (cfg),
    .o_residual_check (residual),
    .o_ana_thr        (ana_thr),
    .o_one_thr        (one_thr),
    .o_two_thr        (two_thr)
  );

  // Clock of 4 ns period.
  always #2 clk = ~clk;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Steps past n edges and lands 1 ns later, so inputs never race the edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Strobes are lowered and an idle edge follows, so calls never collide.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    cyc(1);
    reg_wr    = 1'b0;
    cyc(1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_rd   = 1'b1;
    reg_addr = a;
    cyc(1);
    reg_rd   = 1'b0;
    chk("read valid", 48'h1, 48'(reg_rvalid));
    chk("read data", 48'(exp), 48'(reg_rdata));
    cyc(1);
    chk("read valid end", 48'h0, 48'(reg_rvalid));
  endtask

  // Decode expected from the code tables: tenths of a percent, millivolts.
  function automatic vmc_thr_t exp_thr(input logic [2:0] lo, input logic [2:0] hi,
                                       input logic rng, input logic ana);
    int tab [8] = '{30, 35, 40, 50, 60, 70, 80, 100};
    int m = rng ? 5 : 1;
    exp_thr.low_pct_x10  = 7'(tab[lo]);
    exp_thr.high_pct_x10 = 7'(tab[hi]);
    exp_thr.low_mv       = ana ? 10'h000 : 10'(tab[lo] * m);
    exp_thr.high_mv      = ana ? 10'h000 : 10'(tab[hi] * m);
  endfunction

  task automatic final_report();
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Reset state, and host writes dropped before the default image arrives.
  task automatic t_reset();
    chk("cfg ready", 48'h0, 48'(cfg_ready));
    chk("config image", 48'h0, cfg);
    chk("analog decode", 48'(exp_thr(3'h0, 3'h0, 1'b0, 1'b1)), 48'(ana_thr));
    for (int k = 0; k < 6; k++)
      rd_chk(ofs[k], VMC_RST_REG);
    wr(VMC_OFS_TWO_LEVEL, 8'h55);
    rd_chk(VMC_OFS_TWO_LEVEL, VMC_RST_REG);
  endtask

  task automatic t_nvm();
    nvm_image = 48'h145A_C781_3EA5;
    nvm_valid = 1'b1;
    cyc(1);
    nvm_valid = 1'b0;
    chk("config image", 48'h145A_C781_3EA5, cfg);
    chk("cfg ready", 48'h1, 48'(cfg_ready));
    chk("residual check", 48'h3, 48'(residual));
    chk("one decode", 48'(exp_thr(3'h0, 3'h7, 1'b1, 1'b0)), 48'(one_thr));
    rd_chk(VMC_OFS_ONE_LEVEL, 8'h81);
    rd_chk(VMC_OFS_TWO_LEVEL, 8'hA5);
  endtask

  task automatic t_regs();
    logic [7:0] v [6] = '{8'h10, 8'hC9, 8'hB6, 8'h00, 8'hFF, 8'h7E};
    for (int k = 0; k < 6; k++)
    begin
      wr(ofs[k], v[k]);
      rd_chk(ofs[k], v[k]);
    end
    chk("config image", {v[0], v[1], v[2], v[3], v[4], v[5]}, cfg);
    chk("residual two", 48'h2, 48'(residual));
    wr(VMC_OFS_CONTROL, 8'h04);
    chk("residual one", 48'h1, 48'(residual));
    // Unmapped offset reads zero and leaves every register alone.
    wr(8'h31, 8'hFF);
    rd_chk(8'h31, VMC_UNMAPPED_RDATA);
    chk("config image", {8'h04, v[1], v[2], v[3], v[4], v[5]}, cfg);
  endtask

  // Every code in both ranges; spare bit held at one for analog and two, zero for one, to show it changes nothing.
  task automatic t_decode();
    logic [2:0] c;
    logic       r;
    for (int i = 0; i < 16; i++)
    begin
      c = 3'(i);
      r = i[3];
      wr(VMC_OFS_ANA_WINDOW, {1'b1, r, c, ~c});
      wr(VMC_OFS_ONE_WINDOW, {1'b0, r, c, ~c});
      wr(VMC_OFS_TWO_WINDOW, {1'b1, r, ~c, c});
      chk("analog decode", 48'(exp_thr(c, ~c, r, 1'b1)), 48'(ana_thr));
      chk("one decode", 48'(exp_thr(c, ~c, r, 1'b0)), 48'(one_thr));
      chk("two decode", 48'(exp_thr(~c, c, r, 1'b0)), 48'(two_thr));
      chk("analog nominal", 48'(r), 48'(cfg.ana_win.range_select));
    end
  endtask

  task automatic t_filter();
    wr(VMC_OFS_CONTROL, 8'h00);
    cmp_high = 3'h7;
    cmp_low  = 3'h7;
    cyc(LONG_CYC + 10);
    chk("high flag disabled", 48'h0, 48'(high_flag));
    chk("low flag disabled", 48'h0, 48'(low_flag));
    cmp_high = 3'h0;
    cmp_low  = 3'h0;
    wr(VMC_OFS_CONTROL, 8'h2B);
    // A one-cycle return to normal must restart the long count.
    cmp_high = 3'h7;
    cyc(10);
    cmp_high = 3'h0;
    cyc(1);
    cmp_high = 3'h7;
    cyc(LONG_CYC - 1);
    chk("high flag early", 48'h0, 48'(high_flag));
    cyc(1);
    chk("high flag set", 48'h7, 48'(high_flag));
    wr(VMC_OFS_CONTROL, 8'h23);
    chk("high flag two off", 48'h3, 48'(high_flag));
    wr(VMC_OFS_CONTROL, 8'h21);
    chk("high flag one off", 48'h1, 48'(high_flag));
    cmp_high = 3'h0;
    wr(VMC_OFS_CONTROL, 8'h00);
    wr(VMC_OFS_CONTROL, 8'h0B);
    cmp_low = 3'h7;
    cyc(SHORT_CYC - 1);
    chk("low flag early", 48'h0, 48'(low_flag));
    cyc(1);
    chk("low flag set", 48'h7, 48'(low_flag));
    // Undefined filter codes fall back to the long time, seen on the way down.
    wr(VMC_OFS_CONTROL, 8'h4B);
    cmp_low = 3'h0;
    cyc(LONG_CYC - 1);
    chk("low flag hold", 48'h7, 48'(low_flag));
    cyc(1);
    chk("low flag clear", 48'h0, 48'(low_flag));
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and hang guard
  // ---------------------------------------------------------------------------
  initial
  begin
    clk         = 1'b0;
    rst_n       = 1'b0;
    nvm_valid   = 1'b0;
    nvm_image   = '0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    cmp_high    = 3'h0;
    cmp_low     = 3'h0;
    errors      = 0;
    check_count = 0;
    cyc(8);
    rst_n = 1'b1;
    t_reset();
    t_nvm();
    t_regs();
    t_decode();
    t_filter();
    final_report();
  end

  // A stalled run counts as a mismatch and still reaches the report.
  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    final_report();
  end

endmodule // vmc_bank_tb
